// ==== hdl/dcsl_pkg.sv ====
// Constants, register map and types of the two-channel servo loop.
// Assumes a 200 MHz reference clock and an 8-bit analog sampler per channel.
// Notes on behaviour
// - Position mode samples position every 16 ms and subtracts it from desired position.
// - Error times proportional gain forms one term of the power command.
// - Error change since last period times differential gain adds to command.
// - Position mode uses proportional and differential terms only, no integral.
// - One gain set is shared by both channels.
// - Speed mode runs proportional, integral and differential terms on speed error.
// - Speed mode raises or lowers power until desired speed and direction are met.
// - Mode setting offers separate speed, mixed speed, or speed A with position B.
// - With speed A and position B, only channel A runs the speed loop.
// - Local button path cannot select any closed-loop speed mode.
// - Mid-scale speed feedback reads as zero speed.
// - Full-scale high feedback is +127, full-scale low is -127.
// - Open-loop mode drives the motor from the command, ignoring feedback.
// - Speed mode samples speed every 16 ms and subtracts it from desired speed.
// - Speed mode accumulates error over periods, scaled by integral gain.
`default_nettype none

package dcsl_pkg;
   localparam int CLK_HZ = 200_000_000;
   localparam int LOOP_MS = 16;
   localparam int LOOP_CYCLES = CLK_HZ / 1000 * LOOP_MS;

   localparam int DW = 8;
   localparam int CW = 8;
   localparam int GW = 8;
   localparam int AW = 4;
   localparam int IW = 16;
   localparam int PW = 24;

   // Raw sampler midpoint and clamps
   localparam logic [DW-1:0] ADC_MID = 8'h80;
   localparam logic signed [DW-1:0] FB_MAX = 8'sh7f;
   localparam logic signed [DW-1:0] FB_MIN = -8'sh7f;
   localparam logic signed [CW-1:0] CMD_MAX = 8'sh7f;
   localparam logic signed [CW-1:0] CMD_MIN = -8'sh7f;
   localparam logic signed [IW-1:0] INT_MAX = 16'sh3fff;
   localparam logic signed [IW-1:0] INT_MIN = -16'sh3fff;
   localparam int GAIN_SHIFT = 3;

   // Register offsets
   localparam logic [AW-1:0] REG_MODE = 4'h0;
   localparam logic [AW-1:0] REG_KP = 4'h1;
   localparam logic [AW-1:0] REG_KI = 4'h2;
   localparam logic [AW-1:0] REG_KD = 4'h3;
   localparam logic [AW-1:0] REG_SET_A = 4'h4;
   localparam logic [AW-1:0] REG_SET_B = 4'h5;
   localparam logic [AW-1:0] REG_CMD_A = 4'h6;
   localparam logic [AW-1:0] REG_CMD_B = 4'h7;
   localparam logic [AW-1:0] REG_ERR_A = 4'h8;
   localparam logic [AW-1:0] REG_ERR_B = 4'h9;
   localparam logic [AW-1:0] REG_STAT = 4'ha;

   localparam logic [7:0] KP_RST = 8'h08;
   localparam logic [7:0] KI_RST = 8'h00;
   localparam logic [7:0] KD_RST = 8'h00;

   typedef enum logic [2:0]
   {
      MODE_OPEN = 3'b000,
      MODE_OPEN_A_POS_B = 3'b001,
      MODE_POS_AB = 3'b010,
      MODE_SPD_SEP = 3'b011,
      MODE_SPD_MIX = 3'b100,
      MODE_SPD_A_POS_B = 3'b101
   } dcsl_mode_t;

   typedef enum logic [1:0]
   {
      CH_OPEN = 2'b00,
      CH_POS = 2'b01,
      CH_SPD = 2'b10
   } dcsl_ch_t;
endpackage

`default_nettype wire

// ==== hdl/dcsl_chan.sv ====
// One channel of the servo loop: error, PD or PID terms, saturation.
// Assumes i_tick is a one-cycle pulse per loop period, same clock domain.
`default_nettype none

module dcsl_chan
   import dcsl_pkg::*;
#(
   parameter int W = DW
)
(
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic i_tick,
   input wire logic i_clear,
   input wire dcsl_pkg::dcsl_ch_t i_kind,
   input wire logic signed [W-1:0] i_set,
   input wire logic signed [W-1:0] i_fb,
   input wire logic [GW-1:0] i_kp,
   input wire logic [GW-1:0] i_ki,
   input wire logic [GW-1:0] i_kd,
   output logic signed [CW-1:0] o_cmd,
   output logic signed [W:0] o_err
);
   logic signed [W:0] prev_err;
   logic signed [IW-1:0] acc;
   logic signed [W:0] next_err;
   logic signed [W:0] next_prev_err;
   logic signed [IW-1:0] next_acc;
   logic signed [CW-1:0] next_cmd;
   logic signed [W:0] e;
   logic signed [W+1:0] de;
   logic signed [IW:0] acc_sum;
   logic signed [PW-1:0] sum;

   function automatic logic signed [CW-1:0] sat_cmd(input logic signed [PW-1:0] v);
      if (v > PW'(CMD_MAX))
         sat_cmd = CMD_MAX;
      else if (v < PW'(CMD_MIN))
         sat_cmd = CMD_MIN;
      else
         sat_cmd = v[CW-1:0];
   endfunction

   always_comb
   begin
      next_err = o_err;
      next_prev_err = prev_err;
      next_acc = acc;
      next_cmd = o_cmd;
      e = (W+1)'(i_set) - (W+1)'(i_fb);
      de = (W+2)'(e) - (W+2)'(prev_err);
      acc_sum = (IW+1)'(acc) + (IW+1)'(e);
      sum = '0;
      if (i_clear)
      begin
         next_prev_err = '0;
         next_acc = '0;
      end
      else if (i_tick)
      begin
         case (i_kind)
            CH_OPEN:
            begin
               next_cmd = sat_cmd(PW'(i_set));
               next_err = '0;
               next_prev_err = '0;
               next_acc = '0;
            end
            CH_POS, CH_SPD:
            begin
               sum = PW'(e) * $signed({1'b0, i_kp});
               sum = sum + PW'(de) * $signed({1'b0, i_kd});
               if (i_kind == CH_SPD)
               begin
                  if (acc_sum > (IW+1)'(INT_MAX))
                     next_acc = INT_MAX;
                  else if (acc_sum < (IW+1)'(INT_MIN))
                     next_acc = INT_MIN;
                  else
                     next_acc = acc_sum[IW-1:0];
                  sum = sum + PW'(next_acc) * $signed({1'b0, i_ki});
               end
               else
                  next_acc = '0;
               next_cmd = sat_cmd(sum >>> GAIN_SHIFT);
               next_err = e;
               next_prev_err = e;
            end
            default:
               next_cmd = '0;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         o_err <= '0;
         prev_err <= '0;
         acc <= '0;
         o_cmd <= '0;
      end
      else if (i_ce)
      begin
         o_err <= next_err;
         prev_err <= next_prev_err;
         acc <= next_acc;
         o_cmd <= next_cmd;
      end
   end
endmodule

`default_nettype wire

// ==== hdl/dcsl_top.sv ====
// Top of the two-channel servo loop: registers, loop tick, mode decode.
// Assumes raw 8-bit analog samples arriving asynchronously from samplers.
//
// Decided for this implementation: the address map and the strobed register port.
`default_nettype none

module dcsl_top
   import dcsl_pkg::*;
#(
   parameter int TICK_CYCLES = LOOP_CYCLES
)
(
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic [dcsl_pkg::AW-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_local_cfg,
   input wire logic [dcsl_pkg::DW-1:0] i_adc_a,
   input wire logic [dcsl_pkg::DW-1:0] i_adc_b,
   output logic signed [dcsl_pkg::CW-1:0] o_cmd_a,
   output logic signed [dcsl_pkg::CW-1:0] o_cmd_b,
   output logic o_tick,
   output logic o_mode_refused
);
   import dcsl_pkg::*;

   dcsl_mode_t mode;
   dcsl_mode_t next_mode;
   logic [GW-1:0] kp, ki, kd;
   logic [GW-1:0] next_kp, next_ki, next_kd;
   logic signed [DW-1:0] set_a, set_b;
   logic signed [DW-1:0] next_set_a, next_set_b;
   logic next_refused;
   logic [7:0] next_rdata;
   logic [31:0] tcnt;
   logic [31:0] next_tcnt;
   logic next_tick;
   logic [DW-1:0] adc_a_m, adc_a_s, adc_b_m, adc_b_s;
   logic signed [DW-1:0] fb_a, fb_b, fb_a_sum, fb_a_dif, fb_a_use;
   logic mode_chg;
   dcsl_ch_t kind_a, kind_b;
   logic signed [DW-1:0] sp_a, sp_b;
   logic signed [DW:0] err_a, err_b;

   function automatic logic signed [DW-1:0] adc_to_signed(input logic [DW-1:0] raw);
      logic signed [DW:0] v;
      v = $signed({1'b0, raw}) - $signed({1'b0, ADC_MID});
      if (v > (DW+1)'(FB_MAX))
         adc_to_signed = FB_MAX;
      else if (v < (DW+1)'(FB_MIN))
         adc_to_signed = FB_MIN;
      else
         adc_to_signed = v[DW-1:0];
   endfunction

   function automatic logic signed [DW-1:0] half_sat(input logic signed [DW:0] v);
      logic signed [DW:0] h;
      h = v >>> 1;
      half_sat = h[DW-1:0];
   endfunction

   function automatic logic is_speed(input dcsl_mode_t m);
      is_speed = (m == MODE_SPD_SEP) || (m == MODE_SPD_MIX) || (m == MODE_SPD_A_POS_B);
   endfunction

   // Sampler inputs cross in through two flops
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         adc_a_m <= ADC_MID;
         adc_a_s <= ADC_MID;
         adc_b_m <= ADC_MID;
         adc_b_s <= ADC_MID;
      end
      else if (i_ce)
      begin
         adc_a_m <= i_adc_a;
         adc_a_s <= adc_a_m;
         adc_b_m <= i_adc_b;
         adc_b_s <= adc_b_m;
      end
   end

   assign fb_a = adc_to_signed(adc_a_s);
   assign fb_b = adc_to_signed(adc_b_s);

   // Loop period tick
   always_comb
   begin
      next_tick = 1'b0;
      next_tcnt = tcnt + 32'h1;
      if (tcnt >= 32'(TICK_CYCLES - 1))
      begin
         next_tcnt = '0;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         tcnt <= '0;
         o_tick <= 1'b0;
      end
      else if (i_ce)
      begin
         tcnt <= next_tcnt;
         o_tick <= next_tick;
      end
      else
         o_tick <= 1'b0;
   end

   // Registers
   always_comb
   begin
      next_mode = mode;
      next_kp = kp;
      next_ki = ki;
      next_kd = kd;
      next_set_a = set_a;
      next_set_b = set_b;
      next_refused = o_mode_refused;
      next_rdata = '0;
      if (i_wr)
      begin
         case (i_addr)
            REG_MODE:
            begin
               if (i_local_cfg && is_speed(dcsl_mode_t'(i_wdata[2:0])))
                  next_refused = 1'b1;
               else if (i_wdata[2:0] <= MODE_SPD_A_POS_B)
               begin
                  next_mode = dcsl_mode_t'(i_wdata[2:0]);
                  next_refused = 1'b0;
               end
               else
                  next_refused = 1'b1;
            end
            REG_KP: next_kp = i_wdata;
            REG_KI: next_ki = i_wdata;
            REG_KD: next_kd = i_wdata;
            REG_SET_A: next_set_a = i_wdata;
            REG_SET_B: next_set_b = i_wdata;
            default: next_mode = mode;
         endcase
      end
      if (i_rd)
      begin
         case (i_addr)
            REG_MODE: next_rdata = {5'h00, mode};
            REG_KP: next_rdata = kp;
            REG_KI: next_rdata = ki;
            REG_KD: next_rdata = kd;
            REG_SET_A: next_rdata = set_a;
            REG_SET_B: next_rdata = set_b;
            REG_CMD_A: next_rdata = o_cmd_a;
            REG_CMD_B: next_rdata = o_cmd_b;
            REG_ERR_A: next_rdata = half_sat(err_a);
            REG_ERR_B: next_rdata = half_sat(err_b);
            REG_STAT: next_rdata = {7'h00, o_mode_refused};
            default: next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         mode <= MODE_OPEN;
         kp <= KP_RST;
         ki <= KI_RST;
         kd <= KD_RST;
         set_a <= '0;
         set_b <= '0;
         o_mode_refused <= 1'b0;
         o_rdata <= '0;
         mode_chg <= 1'b0;
      end
      else if (i_ce)
      begin
         mode <= next_mode;
         kp <= next_kp;
         ki <= next_ki;
         kd <= next_kd;
         set_a <= next_set_a;
         set_b <= next_set_b;
         o_mode_refused <= next_refused;
         o_rdata <= next_rdata;
         mode_chg <= (next_mode != mode);
      end
   end

   // Mode decode per channel
   always_comb
   begin
      kind_a = CH_OPEN;
      kind_b = CH_OPEN;
      case (mode)
         MODE_OPEN: kind_b = CH_OPEN;
         MODE_OPEN_A_POS_B: kind_b = CH_POS;
         MODE_POS_AB:
         begin
            kind_a = CH_POS;
            kind_b = CH_POS;
         end
         MODE_SPD_SEP, MODE_SPD_MIX:
         begin
            kind_a = CH_SPD;
            kind_b = CH_SPD;
         end
         MODE_SPD_A_POS_B:
         begin
            kind_a = CH_SPD;
            kind_b = CH_POS;
         end
         default: kind_a = CH_OPEN;
      endcase
   end

   // Mixed mode: A steers half the sum, B steers half the difference of setpoints
   assign fb_a_sum = half_sat((DW+1)'(set_a) + (DW+1)'(set_b));
   assign fb_a_dif = half_sat((DW+1)'(set_a) - (DW+1)'(set_b));
   assign fb_a_use = fb_a;
   assign sp_a = (mode == MODE_SPD_MIX) ? fb_a_sum : set_a;
   assign sp_b = (mode == MODE_SPD_MIX) ? fb_a_dif : set_b;

   dcsl_chan #(.W(DW)) u_chan_a
   (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .i_tick(next_tick),
      .i_clear(mode_chg),
      .i_kind(kind_a),
      .i_set(sp_a),
      .i_fb(fb_a_use),
      .i_kp(kp),
      .i_ki(ki),
      .i_kd(kd),
      .o_cmd(o_cmd_a),
      .o_err(err_a)
   );

   dcsl_chan #(.W(DW)) u_chan_b
   (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .i_tick(next_tick),
      .i_clear(mode_chg),
      .i_kind(kind_b),
      .i_set(sp_b),
      .i_fb(fb_b),
      .i_kp(kp),
      .i_ki(ki),
      .i_kd(kd),
      .o_cmd(o_cmd_b),
      .o_err(err_b)
   );
endmodule

`default_nettype wire

// ==== verification/dcsl_properties.sv ====
// Port-level checks of the two-channel servo loop.
// Assumes binding into dcsl_top; one clock domain.
`default_nettype none

module dcsl_checker
   import dcsl_pkg::*;
#(
   parameter int TICK_CYCLES = LOOP_CYCLES
)
(
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic [dcsl_pkg::AW-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic i_local_cfg,
   input wire logic [dcsl_pkg::DW-1:0] i_adc_a,
   input wire logic [dcsl_pkg::DW-1:0] i_adc_b,
   input wire logic signed [dcsl_pkg::CW-1:0] o_cmd_a,
   input wire logic signed [dcsl_pkg::CW-1:0] o_cmd_b,
   input wire logic o_tick,
   input wire logic o_mode_refused
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] gap, next_gap;
   logic seen, next_seen;

   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);

   // Cycles since the last loop pulse
   always_comb
   begin
      next_gap = o_tick ? 32'h0 : gap + 32'h1;
      next_seen = seen | o_tick;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         gap <= 32'h0;
         seen <= 1'b0;
      end
      else if (i_ce)
      begin
         gap <= next_gap;
         seen <= next_seen;
      end
   end

   sequence s_mode_wr;
      i_ce && i_wr && i_addr == REG_MODE;
   endsequence

   a_refuse_local: assert property (
      s_mode_wr ##0 (i_local_cfg && i_wdata inside {8'h03, 8'h04, 8'h05}) |=> o_mode_refused)
      else $error("speed mode taken from local path");
   a_refuse_code: assert property (
      s_mode_wr ##0 (i_wdata inside {8'h06, 8'h07}) |=> o_mode_refused)
      else $error("unknown mode code taken");
   a_accept_mode: assert property (
      s_mode_wr ##0 (!i_local_cfg && i_wdata < 8'h06) |=> !o_mode_refused)
      else $error("valid mode write refused");
   a_refused_hold: assert property (
      $changed(o_mode_refused) |-> $past(i_wr) && $past(i_addr) == REG_MODE)
      else $error("refused flag moved without a mode write");
   a_tick_period: assert property (
      o_tick && seen |-> gap == TICK_CYCLES - 1)
      else $error("loop period wrong");
   a_tick_pulse: assert property (o_tick |=> !o_tick)
      else $error("loop pulse longer than one cycle");
   a_cmd_range: assert property (o_cmd_a != 8'sh80 && o_cmd_b != 8'sh80)
      else $error("command outside saturation range");
   a_cmd_hold: assert property (
      !$stable(o_cmd_a) || !$stable(o_cmd_b) |-> ##[0:1] o_tick)
      else $error("command changed outside a loop update");
   a_reset_quiet: assert property (
      $fell(i_srst) |-> o_cmd_a == 8'sh00 && o_cmd_b == 8'sh00 && !o_tick && !o_mode_refused)
      else $error("outputs not cleared by reset");
   a_rdata_idle: assert property (i_ce && !i_rd |=> o_rdata == 8'h00)
      else $error("read data outside read answer");
endmodule

bind dcsl_top dcsl_checker #(.TICK_CYCLES(TICK_CYCLES)) dcsl_checker_inst (
   .i_ref_clk, .i_srst, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_local_cfg,
   .i_adc_a, .i_adc_b, .o_cmd_a, .o_cmd_b, .o_tick, .o_mode_refused);

`default_nettype wire

// ==== verification/dcsl_motor.sv ====
// Behavioural power stage with speed sensor for one channel.
// Assumes the command is a signed power level on the bench clock.
`default_nettype none

module dcsl_motor
   import dcsl_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic signed [dcsl_pkg::CW-1:0] i_cmd,
   input wire logic i_hold,
   input wire logic [dcsl_pkg::DW-1:0] i_level,
   output logic [dcsl_pkg::DW-1:0] o_adc
);
   timeunit 1ns;
   timeprecision 100ps;

   // Held sensor level, or speed equal to applied power
   always_ff @(posedge i_ref_clk)
      o_adc <= i_hold ? i_level : ADC_MID + $unsigned(i_cmd);
endmodule

`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench of the servo loop through its register port.
// Assumes dcsl_top, dcsl_motor and the bound checker are compiled first.
`default_nettype none

module tb_top
   import dcsl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TK = 20;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic loc = 1'b0;
   logic hold = 1'b1;
   logic ce = 1'b1;
   int n_frz = 0;
   logic [AW-1:0] addr = '0;
   logic [7:0] wdata = '0, rdata, lvl_a = 8'h80, lvl_b = 8'h80;
   logic [DW-1:0] adc_a, adc_b;
   logic signed [CW-1:0] cmd_a, cmd_b;
   logic tick, refused;
   logic [7:0] spd_b [3] = '{8'h20, 8'h00, 8'h00};
   int n_errors = 0;
   int samples_checked = 0;

   initial forever #2.5 clk = ~clk;

   dcsl_top #(.TICK_CYCLES(TK)) dcsl_top_inst (.i_ref_clk(clk), .i_srst(srst), .i_ce(ce),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_local_cfg(loc), .i_adc_a(adc_a), .i_adc_b(adc_b), .o_cmd_a(cmd_a),
      .o_cmd_b(cmd_b), .o_tick(tick), .o_mode_refused(refused));
   dcsl_motor dcsl_motor_a (.i_ref_clk(clk), .i_cmd(cmd_a), .i_hold(hold),
      .i_level(lvl_a), .o_adc(adc_a));
   dcsl_motor dcsl_motor_b (.i_ref_clk(clk), .i_cmd(cmd_b), .i_hold(hold),
      .i_level(lvl_b), .o_adc(adc_b));

   task automatic stop_test();
      if (n_errors == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %s exp %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [AW-1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [AW-1:0] a, input logic [7:0] exp, input string name);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(name, rdata, exp);
   endtask

   task automatic set_fb(input logic [7:0] a, input logic [7:0] b);
      @(posedge clk);
      lvl_a <= a;
      lvl_b <= b;
   endtask

   // Bounded wait for n loop pulses
   task automatic wait_tick(input int n);
      int k;
      repeat (n)
      begin
         k = 0;
         do
         begin
            @(posedge clk);
            #1;
            k++;
         end
         while (tick !== 1'b1 && k < 4 * TK);
         if (tick !== 1'b1)
         begin
            n_errors++;
            stop_test();
         end
      end
   endtask

   initial
   begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      rd_chk(REG_MODE, 8'h00, "mode");
      rd_chk(REG_KP, KP_RST, "kp");
      rd_chk(REG_KI, KI_RST, "ki");
      rd_chk(REG_KD, KD_RST, "kd");
      rd_chk(4'hb, 8'h00, "unmapped");
      // Open loop ignores far-off feedback
      set_fb(8'h00, 8'hff);
      wr_reg(REG_SET_A, 8'h30);
      wr_reg(REG_SET_B, 8'h81);
      wait_tick(2);
      check("open cmd_a", cmd_a, 8'h30);
      check("open cmd_b", cmd_b, 8'h81);
      // Position loop, integral gain set but unused
      set_fb(8'h90, 8'h90);
      wr_reg(REG_KI, 8'h08);
      wr_reg(REG_KD, 8'h08);
      wr_reg(REG_SET_A, 8'h20);
      wr_reg(REG_SET_B, 8'h20);
      wr_reg(REG_MODE, 8'h02);
      wait_tick(3);
      check("pos cmd_a", cmd_a, 8'h10);
      check("pos cmd_b", cmd_b, 8'h10);
      rd_chk(REG_ERR_A, 8'h08, "err_a");
      wr_reg(REG_SET_A, 8'h28);
      wait_tick(1);
      check("step cmd_a", cmd_a, 8'h20);
      wait_tick(1);
      check("settle cmd_a", cmd_a, 8'h18);
      // Rails of the sensor and of the command
      set_fb(8'h00, 8'hff);
      wr_reg(REG_SET_A, 8'h7f);
      wr_reg(REG_SET_B, 8'h81);
      wait_tick(2);
      check("sat cmd_a", cmd_a, 8'h7f);
      check("sat cmd_b", cmd_b, 8'h81);
      @(posedge clk);
      loc <= 1'b1;
      wr_reg(REG_MODE, 8'h04);
      rd_chk(REG_STAT, 8'h01, "stat");
      rd_chk(REG_MODE, 8'h02, "mode");
      @(posedge clk);
      loc <= 1'b0;
      wr_reg(REG_MODE, 8'h06);
      rd_chk(REG_STAT, 8'h01, "stat");
      rd_chk(REG_MODE, 8'h02, "mode");
      // Speed modes, integral term only
      wr_reg(REG_KP, 8'h00);
      wr_reg(REG_KD, 8'h00);
      set_fb(8'h80, 8'h80);
      wr_reg(REG_SET_A, 8'h10);
      wr_reg(REG_SET_B, 8'h10);
      for (int m = 0; m < 3; m++)
      begin
         wait_tick(1);
         wr_reg(REG_MODE, 8'h03 + 8'(m));
         rd_chk(REG_STAT, 8'h00, "stat");
         wait_tick(2);
         check("spd cmd_a", cmd_a, 8'h20);
         check("spd cmd_b", cmd_b, spd_b[m]);
      end
      // Motor follows power; loop settles on the wanted speed
      @(posedge clk);
      hold <= 1'b0;
      wr_reg(REG_SET_A, 8'h30);
      wr_reg(REG_MODE, 8'h03);
      wait_tick(4);
      check("loop cmd_a", cmd_a, 8'h30);
      check("loop speed_a", adc_a, 8'hb0);
      check("loop cmd_b", cmd_b, 8'h10);
      // Clock enable low freezes loop and outputs
      @(posedge clk);
      ce <= 1'b0;
      repeat (3 * TK)
      begin
         @(posedge clk);
         #1;
         n_frz += int'(tick);
      end
      check("frozen ticks", 8'(n_frz), 8'h00);
      check("frozen cmd_a", cmd_a, 8'h30);
      @(posedge clk);
      ce <= 1'b1;
      wait_tick(2);
      check("resume cmd_a", cmd_a, 8'h30);
      @(posedge clk);
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      #1;
      check("reset cmd_a", cmd_a, 8'h00);
      rd_chk(REG_MODE, 8'h00, "mode");
      stop_test();
   end
endmodule

`default_nettype wire
